// *** pkg/float_coprocessor_defs.svh ***
// Purpose: named constants for the float coprocessor datapath
// Assumes: 64-bit accumulator word, first memory word in bits 63:48
// Notes:   definitions only
`ifndef FLOAT_COPROCESSOR_DEFS_SVH
`define FLOAT_COPROCESSOR_DEFS_SVH

// -----------------------------------------------------------------
// accumulator file
// -----------------------------------------------------------------
`define FC_ACC_NUM      6
`define FC_ACC_LIMIT    3'h6
`define FC_HOST_ACC_NUM 3'h4
`define FC_WORD_ZERO    64'h0000000000000000

// -----------------------------------------------------------------
// float word layout
// -----------------------------------------------------------------
`define FC_SIGN_BIT     63
`define FC_EXP_HI       62
`define FC_EXP_LO       55
`define FC_FRAC_HI      54
`define FC_SGL_LO       32
`define FC_EXP_ZERO     8'h00
`define FC_LOW_ZERO     32'h00000000

// -----------------------------------------------------------------
// exponent arithmetic (excess 200 octal, limits 177 octal)
// -----------------------------------------------------------------
`define FC_EXP_BIAS     10'sh080
`define FC_EXP_BIAS8    8'h80
`define FC_TRUE_MAX     10'sh07f
`define FC_TRUE_MIN     10'sh381
`define FC_TRUE_ZERO    10'sh000
`define FC_SIG_SHIFT    6'h38

// -----------------------------------------------------------------
// integer formats
// -----------------------------------------------------------------
`define FC_SHORT_MAX    10'sh00f
`define FC_LONG_MAX     10'sh01f

`endif

// *** pkg/float_coprocessor_pkg.sv ***
// Purpose: types shared by the float coprocessor datapath
// Assumes: nothing
// Notes:   operation codes and sequencer states
`default_nettype none

package float_coprocessor_pkg;

	typedef enum logic [2:0] {
		OP_LOAD,
		OP_STORE,
		OP_MOVE,
		OP_MUL,
		OP_I2F,
		OP_F2I
	} op_t;

	typedef enum logic {
		ST_IDLE,
		ST_EXEC
	} state_t;

endpackage

`default_nettype wire

// *** hw/float_unpack.sv ***
// Purpose: split a stored float word into sign, exponent, significand
// Assumes: single precision uses the left-most 32 bits only
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "float_coprocessor_defs.svh"

module float_unpack (
	input  wire logic        dbl,
	input  wire logic [63:0] word,
	output logic             sign,
	output logic [7:0]       exp,
	output logic [55:0]      sig,
	output logic             is_zero,
	output logic             is_undef
);

	always_comb
	begin
		sign     = word[`FC_SIGN_BIT];
		exp      = word[`FC_EXP_HI:`FC_EXP_LO];
		is_zero  = (exp == `FC_EXP_ZERO);
		is_undef = is_zero && sign;
		// hidden one restored above the stored fraction
		sig      = {1'b1, word[`FC_FRAC_HI:0]};
		if (!dbl)
			sig = {1'b1, word[`FC_FRAC_HI:`FC_SGL_LO], `FC_LOW_ZERO};
		if (is_zero)
			sig = '0;
	end

endmodule

`default_nettype wire

// *** hw/float_coprocessor.sv ***
// Purpose: float coprocessor datapath with six 64-bit accumulators
// Assumes: host holds command fields stable only in the start cycle
// Notes:   one command at a time; busy from acceptance to write-back
`timescale 1ns/1ps
`default_nettype none
`include "float_coprocessor_defs.svh"

module float_coprocessor (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        start,
	input  wire float_coprocessor_pkg::op_t  op,
	input  wire logic [2:0]                  dst_sel,
	input  wire logic [2:0]                  src_sel,
	input  wire logic [63:0]                 operand_in,
	input  wire logic                        double_precision_select,
	input  wire logic                        long_int_select,
	input  wire logic                        overflow_int_enable,
	input  wire logic                        underflow_int_enable,
	input  wire logic                        undefined_operand_interrupt_enable,
	output logic                             busy,
	output logic                             done,
	output logic [63:0]                      store_data,
	output logic [31:0]                      int_data,
	output logic                             overflow_flag,
	output logic                             underflow_flag,
	output logic                             undefined_flag,
	output logic                             conv_error_flag,
	output logic                             trap,
	output logic                             reject
);
	import float_coprocessor_pkg::*;

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	state_t        state_q;
	logic          busy_q;
	logic          done_q;
	op_t           op_q;
	logic [2:0]    dst_q;
	logic [2:0]    src_q;
	logic [63:0]   operand_q;
	logic          dbl_q;
	logic          long_q;
	logic          ov_ie_q;
	logic          un_ie_q;
	logic          uv_ie_q;
	logic [63:0]   acc_q [`FC_ACC_NUM];
	logic [63:0]   store_q;
	logic [31:0]   int_q;
	logic          ovf_q;
	logic          unf_q;
	logic          undf_q;
	logic          cerr_q;
	logic          trap_q;
	logic          reject_q;

	logic          accept;
	logic          exec;
	logic          host_side;
	logic          reject_w;
	logic [63:0]   acc_rd_dst;
	logic [63:0]   acc_rd_src;
	logic [31:0]   dst_low_w;
	logic [63:0]   b_word;
	logic          a_sign, b_sign;
	logic [7:0]    a_exp, b_exp;
	logic [55:0]   a_sig, b_sig;
	logic          a_zero, b_zero, b_undef;
	logic [111:0]  prod;
	logic [9:0]    texp;
	logic [9:0]    m_exp_sum;
	logic          m_ovf, m_unf;
	logic [54:0]   m_frac;
	logic [31:0]   i_val, i_mag, i_norm;
	logic [4:0]    i_pos;
	logic [63:0]   i_word;
	logic [9:0]    f_texp;
	logic [31:0]   f_mag, f_val;
	logic [63:0]   res_w;
	logic [31:0]   int_w;
	logic          wr_en, st_en, int_en;
	logic          ovf_w, unf_w, undf_w, cerr_w, trap_w;

	assign accept = start && (state_q == ST_IDLE);
	assign exec   = (state_q == ST_EXEC);
	assign busy            = busy_q;
	assign done            = done_q;
	assign store_data      = store_q;
	assign int_data        = int_q;
	assign overflow_flag   = ovf_q;
	assign underflow_flag  = unf_q;
	assign undefined_flag  = undf_q;
	assign conv_error_flag = cerr_q;
	assign trap            = trap_q;
	assign reject          = reject_q;

	// -----------------------------------------------------------------
	// sequencer: one cycle to take, one to execute
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_q <= ST_EXEC;
						busy_q  <= 1'b1;
					end
				end
				ST_EXEC:
				begin
					state_q <= ST_IDLE;
					busy_q  <= 1'b0;
					done_q  <= 1'b1;
				end
				default:
				begin
					state_q <= ST_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	// command and modes are captured at acceptance
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_q      <= OP_LOAD;
			dst_q     <= 3'h0;
			src_q     <= 3'h0;
			operand_q <= `FC_WORD_ZERO;
			dbl_q     <= 1'b0;
			long_q    <= 1'b0;
			ov_ie_q   <= 1'b0;
			un_ie_q   <= 1'b0;
			uv_ie_q   <= 1'b0;
		end
		else if (accept)
		begin
			op_q      <= op;
			dst_q     <= dst_sel;
			src_q     <= src_sel;
			operand_q <= operand_in;
			dbl_q     <= double_precision_select;
			long_q    <= long_int_select;
			ov_ie_q   <= overflow_int_enable;
			un_ie_q   <= underflow_int_enable;
			uv_ie_q   <= undefined_operand_interrupt_enable;
		end
	end

	// -----------------------------------------------------------------
	// operand selection and unpacking
	// -----------------------------------------------------------------
	assign host_side = (op_q == OP_LOAD) || (op_q == OP_STORE) ||
		(op_q == OP_I2F) || (op_q == OP_F2I);
	assign reject_w = (dst_q >= `FC_ACC_LIMIT) ||
		(host_side && (dst_q >= `FC_HOST_ACC_NUM)) ||
		(!host_side && (src_q >= `FC_ACC_LIMIT));
	assign acc_rd_dst = (dst_q < `FC_ACC_LIMIT) ? acc_q[dst_q] : `FC_WORD_ZERO;
	assign acc_rd_src = (src_q < `FC_ACC_LIMIT) ? acc_q[src_q] : `FC_WORD_ZERO;
	assign dst_low_w  = acc_rd_dst[31:0];
	assign b_word = (op_q == OP_LOAD) ? operand_q : acc_rd_src;

	float_unpack u_dst (
		.dbl      (dbl_q),
		.word     (acc_rd_dst),
		.sign     (a_sign),
		.exp      (a_exp),
		.sig      (a_sig),
		.is_zero  (a_zero),
		.is_undef ()
	);

	float_unpack u_src (
		.dbl      (dbl_q),
		.word     (b_word),
		.sign     (b_sign),
		.exp      (b_exp),
		.sig      (b_sig),
		.is_zero  (b_zero),
		.is_undef (b_undef)
	);

	// -----------------------------------------------------------------
	// multiply, convert and pack
	// -----------------------------------------------------------------
	always_comb
	begin
		prod = a_sig * b_sig;
		// product of two fractions in [1/2,1) may need one left shift
		texp = $signed({2'b00, a_exp}) + $signed({2'b00, b_exp}) -
			`FC_EXP_BIAS - `FC_EXP_BIAS - (prod[111] ? 10'sh000 : 10'sh001);
		m_ovf     = $signed(texp) > $signed(`FC_TRUE_MAX);
		m_unf     = $signed(texp) < $signed(`FC_TRUE_MIN);
		m_exp_sum = texp + `FC_EXP_BIAS;
		m_frac    = prod[111] ? prod[110:56] : prod[109:55];
	end

	always_comb
	begin
		i_val = long_q ? operand_q[63:32] : {{16{operand_q[63]}}, operand_q[63:48]};
		i_mag = i_val[31] ? (~i_val + 32'h00000001) : i_val;
		i_pos = 5'h00;
		for (int i = 0; i < 32; i++)
			if (i_mag[i])
				i_pos = 5'(i);
		i_norm = i_mag << (5'h1f - i_pos);
		i_word = {i_val[31], `FC_EXP_BIAS8 + {3'h0, i_pos} + 8'h01, i_norm[30:0], 24'h000000};
		if (i_mag == 32'h00000000)
			i_word = `FC_WORD_ZERO;
	end

	always_comb
	begin
		f_texp = $signed({2'b00, a_exp}) - `FC_EXP_BIAS;
		f_mag  = 32'(a_sig >> (`FC_SIG_SHIFT - f_texp[5:0]));
		f_val  = a_sign ? (~f_mag + 32'h00000001) : f_mag;
	end

	always_comb
	begin
		res_w  = `FC_WORD_ZERO;
		int_w  = 32'h00000000;
		wr_en  = 1'b0;
		st_en  = 1'b0;
		int_en = 1'b0;
		ovf_w  = 1'b0;
		unf_w  = 1'b0;
		undf_w = 1'b0;
		cerr_w = 1'b0;
		trap_w = 1'b0;
		if (!reject_w)
		begin
			case (op_q)
				OP_LOAD:
				begin
					undf_w = b_undef;
					if (b_undef && uv_ie_q)
						trap_w = 1'b1;
					else
					begin
						wr_en = 1'b1;
						res_w = operand_q;
					end
				end
				OP_STORE:
				begin
					st_en = 1'b1;
					res_w = dbl_q ? acc_rd_dst : {acc_rd_dst[63:32], `FC_LOW_ZERO};
				end
				OP_MOVE:
				begin
					wr_en = 1'b1;
					res_w = acc_rd_src;
				end
				OP_MUL:
				begin
					wr_en = 1'b1;
					if (!a_zero && !b_zero)
					begin
						ovf_w  = m_ovf;
						unf_w  = m_unf;
						trap_w = (m_ovf && ov_ie_q) || (m_unf && un_ie_q);
						res_w  = {a_sign ^ b_sign, m_exp_sum[7:0], m_frac};
						if ((m_ovf && !ov_ie_q) || (m_unf && !un_ie_q))
							res_w = `FC_WORD_ZERO;
					end
				end
				OP_I2F:
				begin
					wr_en = 1'b1;
					res_w = i_word;
				end
				OP_F2I:
				begin
					int_en = 1'b1;
					if (!a_zero && ($signed(f_texp) > $signed(`FC_TRUE_ZERO)))
					begin
						if ($signed(f_texp) > $signed(long_q ? `FC_LONG_MAX : `FC_SHORT_MAX))
							cerr_w = 1'b1;
						else
							int_w = long_q ? f_val : {f_val[15:0], 16'h0000};
					end
				end
				default:
				begin
					trap_w = 1'b1;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// accumulators and results
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < `FC_ACC_NUM; i++)
				acc_q[i] <= `FC_WORD_ZERO;
		end
		else if (exec && wr_en)
		begin
			if (dbl_q)
				acc_q[dst_q] <= res_w;
			else
				acc_q[dst_q] <= {res_w[63:32], acc_rd_dst[31:0]};
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			store_q  <= `FC_WORD_ZERO;
			int_q    <= 32'h00000000;
			ovf_q    <= 1'b0;
			unf_q    <= 1'b0;
			undf_q   <= 1'b0;
			cerr_q   <= 1'b0;
			trap_q   <= 1'b0;
			reject_q <= 1'b0;
		end
		else if (exec)
		begin
			if (st_en)
				store_q <= res_w;
			if (int_en)
				int_q <= int_w;
			ovf_q    <= ovf_w;
			unf_q    <= unf_w;
			undf_q   <= undf_w;
			cerr_q   <= cerr_w;
			trap_q   <= trap_w;
			reject_q <= reject_w;
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_BUSY_ON_ACCEPT: assert property (accept |=> busy_q && !done_q)
		else $error("busy not raised after acceptance");
	AST_DONE_NEXT: assert property (accept |=> ##1 (done_q && !busy_q))
		else $error("done not given one cycle after execution");
	AST_SINGLE_KEEPS_LOW: assert property (exec && wr_en && !dbl_q |=>
		acc_q[$past(dst_q)][31:0] == $past(dst_low_w))
		else $error("single precision write changed low word");
	AST_HOST_ACC_LIMIT: assert property (exec && host_side && (dst_q >= `FC_HOST_ACC_NUM)
		|=> reject_q && done_q)
		else $error("host transfer to upper accumulator not refused");
	AST_ZERO_OPERAND: assert property (exec && !reject_w && op_q == OP_MUL && dbl_q &&
		(a_zero || b_zero) |=> acc_q[$past(dst_q)] == `FC_WORD_ZERO && !ovf_q)
		else $error("zero operand did not give exact zero");
	AST_OVERFLOW_FLAG: assert property (exec && !reject_w && op_q == OP_MUL &&
		!a_zero && !b_zero && $signed(texp) > $signed(`FC_TRUE_MAX) |=> ovf_q && !unf_q)
		else $error("overflow not flagged");
	AST_SILENT_OVF_ZERO: assert property (exec && !reject_w && op_q == OP_MUL && dbl_q &&
		ovf_w && !ov_ie_q |=> acc_q[$past(dst_q)] == `FC_WORD_ZERO && !trap_q)
		else $error("disabled overflow did not store exact zero");
	AST_UNDEF_TRAP: assert property (exec && !reject_w && op_q == OP_LOAD && b_undef &&
		uv_ie_q |=> trap_q && undf_q && acc_q[$past(dst_q)] == $past(acc_rd_dst))
		else $error("undefined operand not trapped");
	AST_NO_SECOND_TAKE: assert property (busy_q && start |=> done_q && !busy_q)
		else $error("command taken while busy");

	COV_MUL_OVF: cover property (exec && op_q == OP_MUL && ovf_w);
	COV_LOAD_TRAP: cover property (exec && op_q == OP_LOAD && trap_w);
	COV_I2F: cover property (exec && op_q == OP_I2F ##1 done_q);
	COV_REJECT: cover property (exec && reject_w);

endmodule

`default_nettype wire

// *** sim/host_model.sv ***
// Purpose: host processor model that issues coprocessor commands
// Assumes: one command outstanding at a time; mode bits held like a host status word
// Notes:   after release the operand lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic                   clk,
	input  wire logic                   busy,
	input  wire logic                   done,
	output logic                        start,
	output float_coprocessor_pkg::op_t  op,
	output logic [2:0]                  dst_sel,
	output logic [2:0]                  src_sel,
	output logic [63:0]                 operand_in,
	output logic                        double_precision_select,
	output logic                        long_int_select,
	output logic                        overflow_int_enable,
	output logic                        underflow_int_enable,
	output logic                        undefined_operand_interrupt_enable
);
	import float_coprocessor_pkg::*;

	initial
	begin
		start = 1'b0;
		op = OP_LOAD;
		dst_sel = 3'h0;
		src_sel = 3'h0;
		operand_in = 64'h0;
		{double_precision_select, long_int_select, overflow_int_enable,
			underflow_int_enable, undefined_operand_interrupt_enable} = 5'h00;
	end

	// -----------------------------------------------------------------
	// one command: hold until taken, then stall until done
	// -----------------------------------------------------------------
	task automatic issue(
		input op_t         c,
		input logic [2:0]  d,
		input logic [2:0]  s,
		input logic [63:0] v,
		input logic [4:0]  m,
		output int         n
	);
		logic b;
		start = 1'b1;
		op = c;
		dst_sel = d;
		src_sel = s;
		operand_in = v;
		{double_precision_select, long_int_select, overflow_int_enable,
			underflow_int_enable, undefined_operand_interrupt_enable} = m;
		do
		begin
			b = busy;
			@(posedge clk);
		end
		while (b !== 1'b0);
		#1;
		start = 1'b0;
		operand_in = ~v;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 20);
	endtask

	// start left up through the busy cycle; the design must ignore it there
	task automatic issue_held(
		input op_t         c,
		input logic [2:0]  d,
		input logic [63:0] v,
		input logic [4:0]  m
	);
		start = 1'b1;
		op = c;
		dst_sel = d;
		operand_in = v;
		{double_precision_select, long_int_select, overflow_int_enable,
			underflow_int_enable, undefined_operand_interrupt_enable} = m;
		repeat (2) @(posedge clk);
		#1;
		start = 1'b0;
		operand_in = ~v;
		@(posedge clk);
		#1;
	endtask
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the float coprocessor datapath
// Assumes: host model drives every command input
// Notes:   mode argument is {double, long, overflow en, underflow en, undefined en}
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import float_coprocessor_pkg::*;

	localparam logic [4:0] DBL = 5'h10;
	localparam logic [4:0] LNG = 5'h08;
	localparam logic [4:0] OVE = 5'h04;
	localparam logic [4:0] UNE = 5'h02;
	localparam logic [4:0] UDE = 5'h01;

	logic        clk, rst, start, busy, done;
	op_t         op;
	logic [2:0]  dst_sel, src_sel;
	logic [63:0] operand_in, store_data;
	logic [31:0] int_data;
	logic        double_precision_select, long_int_select;
	logic        overflow_int_enable, underflow_int_enable;
	logic        undefined_operand_interrupt_enable;
	logic        overflow_flag, underflow_flag, undefined_flag;
	logic        conv_error_flag, trap, reject;
	int          n_errors, checked;

	float_coprocessor i_dut (.clk, .rst, .start, .op, .dst_sel, .src_sel, .operand_in,
		.double_precision_select, .long_int_select, .overflow_int_enable,
		.underflow_int_enable, .undefined_operand_interrupt_enable, .busy, .done,
		.store_data, .int_data, .overflow_flag, .underflow_flag, .undefined_flag,
		.conv_error_flag, .trap, .reject);

	host_model i_host (.clk, .busy, .done, .start, .op, .dst_sel, .src_sel, .operand_in,
		.double_precision_select, .long_int_select, .overflow_int_enable,
		.underflow_int_enable, .undefined_operand_interrupt_enable);

	always #5 clk = ~clk;

	// -----------------------------------------------------------------
	// compare and command helpers
	// -----------------------------------------------------------------
	task automatic chk_w(input string what, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_f(input logic [5:0] e);
		logic [5:0] g;
		g = {overflow_flag, underflow_flag, undefined_flag, conv_error_flag, trap, reject};
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD flags expected %h seen %h", e, g);
		end
	endtask

	task automatic run(input op_t c, input logic [2:0] d, s, input logic [63:0] v,
		input logic [4:0] m);
		int n;
		i_host.issue(c, d, s, v, m, n);
		chk_w("latency", 64'h1, 64'(n));
	endtask

	task automatic ld(input logic [2:0] d, input logic [63:0] v, input logic [4:0] m);
		run(OP_LOAD, d, 3'h0, v, m);
	endtask

	task automatic st(input logic [2:0] d, input logic [4:0] m, input logic [63:0] e);
		run(OP_STORE, d, 3'h0, 64'h0, m);
		chk_w("store_data", e, store_data);
	endtask

	task automatic mul(input logic [63:0] a, b, e, input logic [4:0] m,
		input logic [5:0] f);
		ld(3'h1, a, DBL);
		ld(3'h2, b, DBL);
		run(OP_MUL, 3'h1, 3'h2, 64'h0, DBL | m);
		chk_f(f);
		st(3'h1, DBL, e);
	endtask

	task automatic i2f(input logic [63:0] v, input logic [4:0] m, input logic [63:0] e);
		run(OP_I2F, 3'h0, 3'h0, v, m);
		st(3'h0, DBL, e);
	endtask

	task automatic f2i(input logic [63:0] v, input logic [4:0] m, input logic [31:0] e,
		input logic [5:0] f);
		ld(3'h2, v, DBL);
		run(OP_F2I, 3'h2, 3'h0, 64'h0, m);
		chk_w("int_data", {32'h0, e}, {32'h0, int_data});
		chk_f(f);
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_load_store();
		for (int i = 0; i < 4; i++)
			ld(3'(i), 64'h4123_4567_89ab_cde0 + 64'(i), DBL);
		for (int i = 0; i < 4; i++)
			st(3'(i), DBL, 64'h4123_4567_89ab_cde0 + 64'(i));
		run(OP_MOVE, 3'h5, 3'h2, 64'h0, DBL);
		run(OP_MOVE, 3'h4, 3'h5, 64'h0, DBL);
		run(OP_MOVE, 3'h0, 3'h4, 64'h0, DBL);
		st(3'h0, DBL, 64'h4123_4567_89ab_cde2);
		ld(3'h4, 64'h4100_0000_0000_0000, DBL);
		chk_f(6'h01);
		run(OP_STORE, 3'h5, 3'h0, 64'h0, DBL);
		chk_f(6'h01);
		chk_w("store_hold", 64'h4123_4567_89ab_cde2, store_data);
		run(OP_MOVE, 3'h0, 3'h6, 64'h0, DBL);
		chk_f(6'h01);
	endtask

	task automatic t_single();
		ld(3'h1, 64'h1111_2222_3333_4444, DBL);
		ld(3'h1, 64'h5555_6666_7777_8888, 5'h00);
		st(3'h1, DBL, 64'h5555_6666_3333_4444);
		st(3'h1, 5'h00, 64'h5555_6666_0000_0000);
	endtask

	task automatic t_mul();
		mul(64'h4100_0000_0000_0000, 64'h4140_0000_0000_0000,
			64'h41c0_0000_0000_0000, 5'h00, 6'h00);
		mul(64'h4140_0000_0000_0000, 64'h4140_0000_0000_0000,
			64'h4210_0000_0000_0000, 5'h00, 6'h00);
		mul(64'hc100_0000_0000_0000, 64'h4140_0000_0000_0000,
			64'hc1c0_0000_0000_0000, 5'h00, 6'h00);
		mul(64'h6000_0000_0000_0000, 64'h6000_0000_0000_0000,
			64'h7f80_0000_0000_0000, 5'h00, 6'h00);
		mul(64'h7f80_0000_0000_0000, 64'h7f80_0000_0000_0000,
			64'h0, 5'h00, 6'h20);
		mul(64'h7fc0_0000_0000_0000, 64'h7fc0_0000_0000_0000,
			64'h3f10_0000_0000_0000, OVE, 6'h22);
		mul(64'h2080_0000_0000_0000, 64'h2080_0000_0000_0000,
			64'h0080_0000_0000_0000, 5'h00, 6'h00);
		mul(64'h0080_0000_0000_0000, 64'h0080_0000_0000_0000,
			64'h0, 5'h00, 6'h10);
		mul(64'h0080_0000_0000_0000, 64'h0080_0000_0000_0000,
			64'h4080_0000_0000_0000, UNE, 6'h12);
		mul(64'h2080_0000_0000_0000, 64'h2000_0000_0000_0000,
			64'h0, UNE, 6'h12);
		mul(64'h0012_3456_0000_0000, 64'h4100_0000_0000_0000,
			64'h0, 5'h00, 6'h00);
		mul(64'h8000_0000_1234_5678, 64'h4100_0000_0000_0000,
			64'h0, 5'h00, 6'h00);
	endtask

	task automatic t_undef();
		ld(3'h3, 64'h4100_0000_0000_0000, DBL);
		ld(3'h3, 64'h8000_0000_1234_5678, DBL | UDE);
		chk_f(6'h0a);
		st(3'h3, DBL, 64'h4100_0000_0000_0000);
		ld(3'h3, 64'h8000_0000_1234_5678, DBL);
		chk_f(6'h08);
		st(3'h3, DBL, 64'h8000_0000_1234_5678);
	endtask

	task automatic t_conv();
		i2f({16'h0003, 48'h0}, DBL, 64'h4140_0000_0000_0000);
		f2i(64'h4140_0000_0000_0000, DBL, 32'h0003_0000, 6'h00);
		i2f({32'hffff_fffb, 32'h0}, DBL | LNG, 64'hc1a0_0000_0000_0000);
		f2i(64'hc1a0_0000_0000_0000, DBL | LNG, 32'hffff_fffb, 6'h00);
		i2f(64'h0, DBL, 64'h0);
		f2i(64'h4880_0000_0000_0000, DBL, 32'h0, 6'h04);
	endtask

	task automatic t_busy_start();
		i_host.issue_held(OP_LOAD, 3'h0, 64'h4100_0000_0000_0000, DBL);
		chk_w("busy_done_held", 64'h0, {62'h0, busy, done});
		st(3'h0, DBL, 64'h4100_0000_0000_0000);
	endtask

	task automatic report_and_stop();
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		n_errors = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		chk_w("busy_done", 64'h0, {62'h0, busy, done});
		chk_f(6'h00);
		@(posedge clk);
		#1;
		t_load_store();
		t_single();
		t_mul();
		t_undef();
		t_conv();
		t_busy_start();
		report_and_stop();
	end

	initial
	begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule

`default_nettype wire
